// ### av_bridging_port.v
// av_bridging byte stream port: non-throttled byte-wide transmit and receive
// streams between external packetising logic and the mac core.
// assumes mac signals are synchronous to clk_sys_in and mac byte strobes
// follow byte_ce_out; external logic never stalls either stream.
// Overview of operation
// [RULE1] stream clock enable runs at 125 MHz for 1G, 25 MHz for 100M
// [RULE2] byte enable high every stream cycle at 1G, every other at 100M
// [RULE3] transmit ready is the mac byte enable during a transfer
// [RULE4] transmit ready goes high whenever a new frame can start
// [RULE5] external logic raises valid with the first byte together
// [RULE6] external logic gives a fresh byte on every ready cycle
// [RULE7] external logic never pauses a transmit frame once started
// [RULE8] after first byte ready stays low until the mac starts sending
// [RULE9] external logic marks last for one ready cycle on the final byte
// [RULE10] valid drops with last unless another frame follows back to back
// [RULE11] transmit user flag is carried but aborts nothing
// [RULE12] both data paths are one byte wide with no strobes
// [RULE13] receive valid follows the receive byte enable like transmit
// [RULE14] received bridging frame gives a new byte on every valid cycle
// [RULE15] receiver takes every valid byte and is always ready
// [RULE16] valid stays low after the second-to-last byte until good or bad
// [RULE17] on good or bad the final byte goes out with last high
// [RULE18] receive user is high for a bad frame, low for good
// [RULE19] every filtered frame is forwarded, good or bad alike
// [RULE20] bridging and ordinary frames are muxed by priority and time slot
// [RULE21] receive last and user stay low outside the final-byte cycle
`include "av_bridging_port_regs.vh"

module av_bridging_port #(
    parameter SPEED_SEL_RESET = 1'b1  // unused; speed_1g_in alone selects 1G or 100M
) (
    input  wire       clk_sys_in,          // 200 MHz system clock
    input  wire       rst_n_in,            // async reset, active low
    input  wire       speed_1g_in,         // 1 = 1 Gb/s, 0 = 100 Mb/s
    output reg        stream_ce_out,       // stream clock enable pulse
    output reg        byte_ce_out,         // mac byte enable pulse
    // bridging transmit stream
    input  wire [7:0] av_tx_tdata_in,      // transmit byte
    input  wire       av_tx_tvalid_in,     // transmit valid
    input  wire       av_tx_tlast_in,      // final byte
    input  wire       av_tx_tuser_in,      // frame error flag
    output reg        av_tx_tready_out,    // byte strobe / ready
    // ordinary transmit stream, same signalling
    input  wire [7:0] lg_tx_tdata_in,      // transmit byte
    input  wire       lg_tx_tvalid_in,     // transmit valid
    input  wire       lg_tx_tlast_in,      // final byte
    output reg        lg_tx_tready_out,    // byte strobe / ready
    // toward the mac transmitter
    output reg  [7:0] mac_tx_data_out,     // byte to mac
    output reg        mac_tx_valid_out,    // byte present
    output reg        mac_tx_last_out,     // final byte
    output reg        mac_tx_user_out,     // error flag, unconnected in mac
    input  wire       mac_tx_ack_in,       // mac took first byte, started
    // from the mac receiver, already address filtered
    input  wire [7:0] mac_rx_data_in,      // received byte
    input  wire       mac_rx_valid_in,     // byte strobe from mac
    input  wire       mac_rx_good_in,      // frame good pulse
    input  wire       mac_rx_bad_in,       // frame bad pulse
    input  wire       mac_rx_bridging_in,  // frame is a bridging frame
    // bridging receive stream
    output reg  [7:0] av_rx_tdata_out,     // received byte
    output reg        av_rx_tvalid_out,    // byte strobe
    output reg        av_rx_tlast_out,     // final byte
    output reg        av_rx_tuser_out,     // bad frame flag
    // ordinary receive stream
    output reg  [7:0] lg_rx_tdata_out,     // received byte
    output reg        lg_rx_tvalid_out,    // byte strobe
    output reg        lg_rx_tlast_out,     // final byte
    output reg        lg_rx_tuser_out      // bad frame flag
);
    localparam [`ACC_W-1:0] MOD     = `CLK_SYS_MHZ;
    localparam [`ACC_W-1:0] STEP_1G = `STREAM_1G_MHZ;
    localparam [`ACC_W-1:0] STEP_FE = `STREAM_100M_MHZ;

    reg  [`ACC_W-1:0] acc;
    reg  [`ACC_W-1:0] next_acc;
    reg               next_stream_ce;
    reg               next_byte_ce;
    reg               half;
    reg  [1:0]        tx_state;
    reg  [1:0]        next_tx_state;
    reg               owner_av;
    reg               next_owner_av;
    reg               mac_started;
    reg  [15:0]       slot_cnt;
    reg               next_av_ready;
    reg               next_lg_ready;
    reg  [7:0]        hold_data;
    reg               hold_valid;
    reg               rx_frame_av;

    wire [`ACC_W:0]   acc_sum;
    wire              av_push;
    wire              lg_push;
    wire              push;
    wire [`FIFO_WIDTH-1:0] push_word;
    wire              fifo_wr_ready;
    wire              fifo_rd_valid;
    wire [`FIFO_WIDTH-1:0] fifo_rd_data;
    wire              mac_pop;
    wire              load_out;
    wire              slot_reserved;
    wire              rx_end;
    wire              rx_bad;

    // phase accumulator: adds the stream rate, wraps at the system rate
    assign acc_sum = {1'b0, acc} + {1'b0, (speed_1g_in ? STEP_1G : STEP_FE)};

    always @* begin
        next_stream_ce = (acc_sum >= {1'b0, MOD});                      // RULE1
        next_acc       = next_stream_ce ? acc_sum[`ACC_W-1:0] - MOD : acc_sum[`ACC_W-1:0];
        next_byte_ce   = next_stream_ce & (speed_1g_in | half);         // RULE2
    end

    // enables are registered so outputs and internal users see the same pulse
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc           <= {`ACC_W{1'b0}};
            stream_ce_out <= 1'b0;
            byte_ce_out   <= 1'b0;
            half          <= 1'b0;
        end else begin
            acc           <= next_acc;
            stream_ce_out <= next_stream_ce;
            byte_ce_out   <= next_byte_ce;
            if (next_stream_ce) begin
                half <= ~half;
            end
        end
    end

    // time slot: the first part of each period is reserved for bridging starts
    assign slot_reserved = (slot_cnt < `SLOT_RESERVED);

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slot_cnt <= 16'h0000;
        end else begin
            slot_cnt <= (slot_cnt == `SLOT_PERIOD - 16'h0001) ? 16'h0000 : slot_cnt + 16'h0001;
        end
    end

    // only the owning stream may push; readies are exclusive by construction
    assign av_push   = av_tx_tvalid_in & av_tx_tready_out;
    assign lg_push   = lg_tx_tvalid_in & lg_tx_tready_out;
    assign push      = av_push | lg_push;
    assign push_word = av_push ? {av_tx_tuser_in, av_tx_tlast_in, av_tx_tdata_in}   // RULE12
                               : {1'b0, lg_tx_tlast_in, lg_tx_tdata_in};

    // transmit sequencing and the ready strobes for the next cycle
    always @* begin
        next_tx_state = tx_state;
        next_owner_av = owner_av;
        next_av_ready = 1'b0;
        next_lg_ready = 1'b0;
        case (tx_state)
            `TX_IDLE: begin
                if (push) begin
                    next_owner_av = av_push;                           // RULE20
                    next_tx_state = push_word[8] ? `TX_DRAIN : `TX_WAIT_START;
                end
            end
            `TX_WAIT_START: begin
                if (mac_tx_ack_in) begin                                // RULE8
                    next_tx_state = `TX_SEND;
                end
            end
            `TX_SEND: begin
                if (push && push_word[8]) begin
                    next_tx_state = `TX_DRAIN;
                end
            end
            `TX_DRAIN: begin
                if (mac_pop && mac_tx_last_out) begin
                    next_tx_state = `TX_IDLE;
                end
            end
            default: begin
                next_tx_state = `TX_IDLE;
            end
        endcase
        // a new frame is offered on every byte enable while idle
        if (next_tx_state == `TX_IDLE && next_byte_ce && fifo_wr_ready) begin
            if (slot_reserved || av_tx_tvalid_in) begin
                next_av_ready = 1'b1;                                   // RULE4
            end else begin
                next_lg_ready = 1'b1;                                   // RULE20
            end
        end
        // mid-frame the ready is the mac byte enable itself
        if (next_tx_state == `TX_SEND && next_byte_ce && fifo_wr_ready) begin
            next_av_ready = next_owner_av;                              // RULE3
            next_lg_ready = ~next_owner_av;
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_state         <= `TX_IDLE;
            owner_av         <= 1'b0;
            av_tx_tready_out <= 1'b0;
            lg_tx_tready_out <= 1'b0;
        end else begin
            tx_state         <= next_tx_state;
            owner_av         <= next_owner_av;
            av_tx_tready_out <= next_av_ready;
            lg_tx_tready_out <= next_lg_ready;
        end
    end

    // the fifo absorbs the wait for the mac start; a full fifo drops ready
    av_byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (3)
    ) u_tx_fifo (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .wr_valid_in  (push),
        .wr_ready_out (fifo_wr_ready),
        .wr_data_in   (push_word),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (load_out),
        .rd_data_out  (fifo_rd_data)
    );

    // mac takes the first byte by its ack, later bytes on each byte enable
    assign mac_pop  = mac_tx_valid_out & (mac_tx_ack_in | (mac_started & byte_ce_out));
    assign load_out = fifo_rd_valid & (~mac_tx_valid_out | mac_pop);

    // output stage to the mac; the user flag is passed on but aborts nothing
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mac_tx_data_out  <= 8'h00;
            mac_tx_valid_out <= 1'b0;
            mac_tx_last_out  <= 1'b0;
            mac_tx_user_out  <= 1'b0;
            mac_started      <= 1'b0;
        end else begin
            if (load_out) begin
                mac_tx_data_out  <= fifo_rd_data[7:0];
                mac_tx_last_out  <= fifo_rd_data[8];
                mac_tx_user_out  <= fifo_rd_data[9];                    // RULE11
                mac_tx_valid_out <= 1'b1;
            end else if (mac_pop) begin
                mac_tx_valid_out <= 1'b0;
            end
            if (mac_pop && mac_tx_last_out) begin
                mac_started <= 1'b0;
            end else if (mac_tx_ack_in) begin
                mac_started <= 1'b1;
            end
        end
    end

    // receive: one byte is held back so the final byte waits for good or bad
    assign rx_end = mac_rx_good_in | mac_rx_bad_in;
    assign rx_bad = mac_rx_bad_in;

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_data        <= 8'h00;
            hold_valid       <= 1'b0;
            rx_frame_av      <= 1'b0;
            av_rx_tdata_out  <= 8'h00;
            av_rx_tvalid_out <= 1'b0;
            av_rx_tlast_out  <= 1'b0;
            av_rx_tuser_out  <= 1'b0;
            lg_rx_tdata_out  <= 8'h00;
            lg_rx_tvalid_out <= 1'b0;
            lg_rx_tlast_out  <= 1'b0;
            lg_rx_tuser_out  <= 1'b0;
        end else begin
            // strobes, last and user default low each cycle
            av_rx_tvalid_out <= 1'b0;
            av_rx_tlast_out  <= 1'b0;                                   // RULE21
            av_rx_tuser_out  <= 1'b0;                                   // RULE21
            lg_rx_tvalid_out <= 1'b0;
            lg_rx_tlast_out  <= 1'b0;
            lg_rx_tuser_out  <= 1'b0;
            if (mac_rx_valid_in) begin
                hold_data  <= mac_rx_data_in;
                hold_valid <= 1'b1;
                if (!hold_valid) begin
                    rx_frame_av <= mac_rx_bridging_in;
                end
            end
            // the held byte leaves when the next one arrives, so valid follows
            // the mac byte enable and goes quiet after the second-to-last byte
            if (mac_rx_valid_in && hold_valid && !rx_end) begin
                if (rx_frame_av) begin
                    av_rx_tdata_out  <= hold_data;                      // RULE14
                    av_rx_tvalid_out <= 1'b1;                           // RULE13
                end else begin
                    lg_rx_tdata_out  <= hold_data;
                    lg_rx_tvalid_out <= 1'b1;                           // RULE20
                end
            end
            // good or bad releases the final byte; bad frames still pass
            if (rx_end && hold_valid) begin                             // RULE16
                hold_valid <= 1'b0;
                if (rx_frame_av) begin
                    av_rx_tdata_out  <= hold_data;
                    av_rx_tvalid_out <= 1'b1;                           // RULE17
                    av_rx_tlast_out  <= 1'b1;                           // RULE19
                    av_rx_tuser_out  <= rx_bad;                         // RULE18
                end else begin
                    lg_rx_tdata_out  <= hold_data;
                    lg_rx_tvalid_out <= 1'b1;
                    lg_rx_tlast_out  <= 1'b1;
                    lg_rx_tuser_out  <= rx_bad;
                end
            end
        end
    end
endmodule // av_bridging_port

// ### av_bridging_port_regs.vh
// constants for the av_bridging byte stream port: rates, fifo shape, states.
// assumes a 200 MHz system clock; all stream rates are enables made from it.
`ifndef AV_BRIDGING_PORT_REGS_VH
`define AV_BRIDGING_PORT_REGS_VH

// clock rates in MHz, as printed
`define CLK_SYS_MHZ        200
`define STREAM_1G_MHZ      125
`define STREAM_100M_MHZ    25

// phase accumulator width for the stream clock enable
`define ACC_W              8

// data fifo between the stream and the mac: {user, last, byte}
`define FIFO_DEPTH         8
`define FIFO_WIDTH         10
`define BYTE_W             8

// transmit states
`define TX_IDLE            2'h0
`define TX_WAIT_START      2'h1
`define TX_SEND            2'h2
`define TX_DRAIN           2'h3

// time slot scheduler: cycles of the whole slot period and of the reserved part
`define SLOT_PERIOD        16'h0400
`define SLOT_RESERVED      16'h0100

`endif

// ### av_byte_fifo.v
// synchronous fifo with valid/ready on both sides, honest full and empty.
// assumes one clock and an active-low asynchronous reset.
module av_byte_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys_in,   // system clock
    input  wire             rst_n_in,     // async reset, active low
    input  wire             wr_valid_in,  // write request
    output wire             wr_ready_out, // room for a word
    input  wire [WIDTH-1:0] wr_data_in,   // word written
    output wire             rd_valid_out, // a word is waiting
    input  wire             rd_ready_in,  // reader takes the word
    output wire [WIDTH-1:0] rd_data_out   // oldest word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;

    // full and empty come straight from the occupancy count
    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != {(AW+1){1'b0}});
    assign rd_data_out  = mem[rd_ptr];
    assign do_wr        = wr_valid_in & wr_ready_out;
    assign do_rd        = rd_valid_out & rd_ready_in;

    // storage has no reset; only the pointers and the count need a defined start
    always @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    // pointers wrap at depth, count tracks occupancy
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // av_byte_fifo

// ### av_bridging_port_asserts.sv
// checker for the av_bridging byte stream port: enables, tx ready, rx framing.
// assumes it is bound to av_bridging_port and sees only its ports.
module av_bridging_port_asserts (
    input wire       clk_sys_in,       // system clock
    input wire       rst_n_in,         // async reset, active low
    input wire       speed_1g_in,      // speed select
    input wire       stream_ce_out,    // stream enable
    input wire       byte_ce_out,      // byte enable
    input wire       av_tx_tvalid_in,  // tx valid
    input wire       av_tx_tlast_in,   // tx last
    input wire       av_tx_tready_out, // tx ready
    input wire       lg_tx_tready_out, // ordinary tx ready
    input wire       mac_tx_ack_in,    // mac started
    input wire       mac_rx_valid_in,  // mac rx byte
    input wire       mac_rx_good_in,   // frame good
    input wire       mac_rx_bad_in,    // frame bad
    input wire       av_rx_tvalid_out, // rx valid
    input wire       av_rx_tlast_out,  // rx last
    input wire       av_rx_tuser_out,  // rx bad flag
    input wire       lg_rx_tvalid_out  // ordinary rx valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [2:0] up;
    logic       inframe;
    logic       waiting;
    // up skips the first edges, where the enable phase is still settling
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up <= 3'h0;
            inframe <= 1'b0;
            waiting <= 1'b0;
        end else begin
            if (up != 3'h7) up <= up + 3'h1;
            if (av_tx_tvalid_in && av_tx_tready_out) inframe <= !av_tx_tlast_in;
            if (av_tx_tvalid_in && av_tx_tready_out && !inframe) waiting <= 1'b1;
            else if (mac_tx_ack_in) waiting <= 1'b0;
        end
    end
    ce_nest_a: assert property (byte_ce_out |-> stream_ce_out)
        else $error("byte enable without stream enable");
    gig_rate_a: assert property (speed_1g_in && up == 3'h7 && !stream_ce_out |=> stream_ce_out)
        else $error("stream enable gap too long at 1G");
    gig_byte_a: assert property (speed_1g_in && stream_ce_out |-> byte_ce_out)
        else $error("byte enable missing at 1G");
    slow_rate_a: assert property (!speed_1g_in && stream_ce_out |=> !stream_ce_out[*7] ##1 stream_ce_out)
        else $error("stream enable period wrong at 100M");
    slow_byte_a: assert property (!speed_1g_in && byte_ce_out |=> !byte_ce_out[*8])
        else $error("byte enable too often at 100M");
    ready_strobe_a: assert property (av_tx_tready_out |-> byte_ce_out)
        else $error("tx ready off the byte enable");
    ready_hold_a: assert property (waiting |-> !av_tx_tready_out)
        else $error("tx ready before mac started");
    stream_mux_a: assert property (!(av_tx_tready_out && lg_tx_tready_out) && !(av_rx_tvalid_out && lg_rx_tvalid_out))
        else $error("both stream classes active at once");
    rx_byte_a: assert property (av_rx_tvalid_out && !av_rx_tlast_out |-> $past(mac_rx_valid_in))
        else $error("rx byte without mac byte");
    rx_end_a: assert property (av_rx_tlast_out |-> av_rx_tvalid_out && ($past(mac_rx_good_in) || $past(mac_rx_bad_in)))
        else $error("rx last without good or bad");
    rx_flag_a: assert property (av_rx_tlast_out |-> av_rx_tuser_out == $past(mac_rx_bad_in))
        else $error("rx user does not match frame status");
    rx_user_a: assert property (av_rx_tuser_out |-> av_rx_tlast_out)
        else $error("rx user outside last byte");
    tx_start_c: cover property (waiting && mac_tx_ack_in);
    rx_good_c: cover property (av_rx_tlast_out && !av_rx_tuser_out);
    rx_bad_c: cover property (av_rx_tlast_out && av_rx_tuser_out);
endmodule // av_bridging_port_asserts

// ### av_packetiser_model.sv
// packetiser stand-in: sends tx frames on ready, collects rx bytes.
// assumes the bench holds go_in across one rising edge; never stalls.
module av_packetiser_model (
    input  wire        clk_sys_in,    // system clock
    input  wire        go_in,         // start a burst of frames
    input  wire  [3:0] frames_in,     // frames in the burst
    input  wire  [3:0] len_in,        // bytes per frame
    input  wire        err_in,        // flag frames as errored
    input  wire        tready_in,     // device byte strobe
    output logic [7:0] tdata_out,     // tx byte
    output logic       tvalid_out,    // tx valid
    output logic       tlast_out,     // tx last
    output logic       tuser_out,     // tx error flag
    input  wire  [7:0] rx_tdata_in,   // rx byte
    input  wire        rx_tvalid_in,  // rx strobe
    input  wire        rx_tlast_in,   // rx last
    input  wire        rx_tuser_in    // rx bad flag
);
    timeunit 1ns;
    timeprecision 1ps;
    int         k = 0;
    int         tot = 0;
    logic       take = 1'b0;
    logic       start = 1'b0;
    logic [9:0] rxq[$];
    initial {tdata_out, tvalid_out, tlast_out, tuser_out} = 11'h000;
    // sample on the rising edge so the falling-edge update never races it
    always @(posedge clk_sys_in) begin
        take <= tvalid_out & tready_in;
        start <= go_in;
    end
    // idle data toggles so a stale byte cannot pass for a fresh one
    always @(negedge clk_sys_in) begin
        if (start) begin
            k = 0;
            tot = frames_in * len_in;
        end else if (take) k = k + 1;
        tvalid_out <= k < tot;
        tdata_out <= (k < tot) ? (8'(k) ^ 8'h5a) : ~tdata_out;
        tlast_out <= (k < tot) && (k % len_in == len_in - 1);
        tuser_out <= (k < tot) && err_in;
    end
    // receiver is always ready and takes every strobed byte
    always @(posedge clk_sys_in)
        if (rx_tvalid_in === 1'b1) rxq.push_back({rx_tuser_in, rx_tlast_in, rx_tdata_in});
endmodule // av_packetiser_model

// ### av_bridging_port_tb.sv
// bench for the av_bridging port: enable rates, tx bursts, rx good/bad/ordinary.
// assumes the packetiser model drives the av tx stream; the mac is modelled here.
module av_bridging_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, speed_1g_in = 1'b1, go = 1'b0, err = 1'b0;
    logic mac_tx_ack_in = 1'b0, mac_rx_valid_in = 1'b0, mac_rx_good_in = 1'b0;
    logic mac_rx_bad_in = 1'b0, mac_rx_bridging_in = 1'b0, sending = 1'b0;
    logic [7:0] mac_rx_data_in = 8'h00;
    logic [3:0] frames = 4'h1, len = 4'h1;
    wire stream_ce_out, byte_ce_out, av_tx_tvalid_in, av_tx_tlast_in, av_tx_tuser_in;
    wire av_tx_tready_out, lg_tx_tready_out, mac_tx_valid_out, mac_tx_last_out, mac_tx_user_out;
    wire [7:0] av_tx_tdata_in, mac_tx_data_out, av_rx_tdata_out, lg_rx_tdata_out;
    wire av_rx_tvalid_out, av_rx_tlast_out, av_rx_tuser_out;
    wire lg_rx_tvalid_out, lg_rx_tlast_out, lg_rx_tuser_out;
    int errors = 0, n_tests = 0, w = 0;
    logic [9:0] mq[$], lq[$];
    av_bridging_port i_av_bridging_port (.*, .lg_tx_tdata_in(8'h00), .lg_tx_tvalid_in(1'b0),
        .lg_tx_tlast_in(1'b0));
    av_packetiser_model i_av_packetiser_model (.clk_sys_in(clk_sys_in), .go_in(go),
        .frames_in(frames), .len_in(len), .err_in(err), .tready_in(av_tx_tready_out),
        .tdata_out(av_tx_tdata_in), .tvalid_out(av_tx_tvalid_in), .tlast_out(av_tx_tlast_in),
        .tuser_out(av_tx_tuser_in), .rx_tdata_in(av_rx_tdata_out),
        .rx_tvalid_in(av_rx_tvalid_out), .rx_tlast_in(av_rx_tlast_out),
        .rx_tuser_in(av_rx_tuser_out));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    // mac transmitter: slow start on the first byte, then pops on each byte enable
    always @(negedge clk_sys_in) begin
        if (mac_tx_ack_in) mac_tx_ack_in = 1'b0;
        else if (mac_tx_valid_out === 1'b1 && !sending) begin
            w = w + 1;
            if (w == 6) begin
                mac_tx_ack_in = 1'b1;
                w = 0;
            end
        end
    end
    always @(posedge clk_sys_in) begin
        if (mac_tx_valid_out === 1'b1 && (mac_tx_ack_in || (sending && byte_ce_out))) begin
            mq.push_back({mac_tx_user_out, mac_tx_last_out, mac_tx_data_out});
            sending <= !mac_tx_last_out;
        end
        if (lg_rx_tvalid_out === 1'b1)
            lq.push_back({lg_rx_tuser_out, lg_rx_tlast_out, lg_rx_tdata_out});
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic reset_dut(input logic s);
        rst_n_in = 1'b0;
        speed_1g_in = s;
        sending = 1'b0;
        w = 0;
        repeat (10) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
    endtask
    // count enables over a window that is a whole number of phase periods
    task automatic t_rate(input logic s);
        int nb = 0, ns = 0;
        reset_dut(s);
        repeat (400) begin
            @(negedge clk_sys_in);
            if (byte_ce_out === 1'b1) nb++;
            if (stream_ce_out === 1'b1) ns++;
        end
        chk("byte enables", nb, s ? 250 : 25);
        chk("stream enables", ns, s ? 250 : 50);
        $display("rate test done speed %0d", s);
    endtask
    task automatic t_tx(input int nf, input int nl, input logic e);
        int tot;
        tot = nf * nl;
        mq.delete();
        frames = 4'(nf);
        len = 4'(nl);
        err = e;
        go = 1'b1;
        @(negedge clk_sys_in);
        go = 1'b0;
        for (int i = 0; i < 4000 && mq.size() < tot; i++) @(negedge clk_sys_in);
        chk("tx byte count", mq.size(), tot);
        foreach (mq[i]) begin
            chk("tx byte", mq[i][7:0], i[7:0] ^ 8'h5a);
            chk("tx last", mq[i][8], (i % nl) == nl - 1);
            chk("tx user", mq[i][9], e);
        end
        repeat (20) @(negedge clk_sys_in);
        $display("tx test done frames %0d", nf);
    endtask
    task automatic t_rx(input int nl, input logic bad, input logic br);
        int n0, l0;
        n0 = i_av_packetiser_model.rxq.size();
        l0 = lq.size();
        mac_rx_bridging_in = br;
        for (int i = 0; i < nl; i++) begin
            mac_rx_valid_in = 1'b1;
            mac_rx_data_in = 8'(i * 3 + 1);
            @(negedge clk_sys_in);
            mac_rx_valid_in = 1'b0;
            mac_rx_data_in = ~mac_rx_data_in;
            repeat (2) @(negedge clk_sys_in);
        end
        {mac_rx_good_in, mac_rx_bad_in} = {!bad, bad};
        @(negedge clk_sys_in);
        {mac_rx_good_in, mac_rx_bad_in} = 2'h0;
        repeat (4) @(negedge clk_sys_in);
        chk("rx av count", i_av_packetiser_model.rxq.size() - n0, br ? nl : 0);
        chk("rx lg count", lq.size() - l0, br ? 0 : nl);
        for (int i = 0; i < nl; i++)
            chk("rx entry", br ? i_av_packetiser_model.rxq[n0 + i] : lq[l0 + i],
                {bad && i == nl - 1, i == nl - 1, 8'(i * 3 + 1)});
        $display("rx test done bad %0d bridging %0d", bad, br);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        final_report;
    end
    initial begin
        t_rate(1'b1);
        t_tx(1, 5, 1'b0);
        t_tx(3, 4, 1'b1);
        t_rx(6, 1'b0, 1'b1);
        t_rx(5, 1'b1, 1'b1);
        t_rx(4, 1'b0, 1'b0);
        t_rate(1'b0);
        t_tx(2, 3, 1'b0);
        t_rx(3, 1'b1, 1'b1);
        final_report;
    end
endmodule // av_bridging_port_tb
bind av_bridging_port av_bridging_port_asserts i_av_bridging_port_asserts (.*);
